// ==== common/snf_pkg.sv ====
/*
  Constants, register map, opcodes and state types for the serial NAND
  command front end host controller.
  Assumes a 100 MHz system clock and a flash device on a four-line serial bus.

*/
package snf_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_HALF_NS = 40;
  // least time rounds up; also leaves room for the two-flop input delay
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SCK_HALF_LAST = 3'(SCK_HALF_CYC - 1);

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_OPCODE = 4'h1;
  localparam logic [3:0] REG_ADDR = 4'h2;
  localparam logic [3:0] REG_LEN = 4'h3;
  localparam logic [3:0] REG_DATA = 4'h4;

  localparam int CTRL_GO = 0;
  localparam int CTRL_MODE3 = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_MODE3 = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_TX_NEED = 3;
  localparam int STAT_RX_VALID = 4;

  localparam logic [7:0] OP_RESET = 8'hFF;
  localparam logic [7:0] OP_GET_FEAT = 8'h0F;
  localparam logic [7:0] OP_SET_FEAT = 8'h1F;
  localparam logic [7:0] OP_READ_ID = 8'h9F;
  localparam logic [7:0] OP_PAGE_READ = 8'h13;
  localparam logic [7:0] OP_CACHE_RAND = 8'h30;
  localparam logic [7:0] OP_CACHE_LAST = 8'h3F;
  localparam logic [7:0] OP_RD_X1 = 8'h03;
  localparam logic [7:0] OP_RD_X1_FAST = 8'h0B;
  localparam logic [7:0] OP_RD_X2 = 8'h3B;
  localparam logic [7:0] OP_RD_X4 = 8'h6B;
  localparam logic [7:0] OP_RD_DIO = 8'hBB;
  localparam logic [7:0] OP_RD_QIO = 8'hEB;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_ERASE = 8'hD8;
  localparam logic [7:0] OP_PROG_EXEC = 8'h10;
  localparam logic [7:0] OP_LOAD_X1 = 8'h02;
  localparam logic [7:0] OP_LOAD_X4 = 8'h32;
  localparam logic [7:0] OP_LOAD_RAND_X1 = 8'h84;
  localparam logic [7:0] OP_LOAD_RAND_X4 = 8'h34;
  localparam logic [7:0] OP_PERM_LOCK = 8'h2C;

  localparam logic [11:0] COL_LAST = 12'h87F;
  localparam logic [12:0] PAGE_BYTES = 13'h0880;
  localparam logic [11:0] FEAT_BYTES = 12'h001;
  localparam logic [11:0] ID_BYTES = 12'h002;

  localparam logic [2:0] LANE1 = 3'h1;
  localparam logic [2:0] LANE2 = 3'h2;
  localparam logic [2:0] LANE4 = 3'h4;

  localparam logic [3:0] PIN_IDLE_OUT = 4'hC;
  localparam logic [3:0] PIN_IDLE_OE = 4'hD;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b011,
    ST_STALL = 3'b100,
    ST_END = 3'b101,
    ST_GAP = 3'b110
  } snf_state_t;

  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_ADDR = 2'b01,
    PH_DUMMY = 2'b10,
    PH_DATA = 2'b11
  } snf_phase_t;
endpackage : snf_pkg

// ==== rtl/snf_host.sv ====
/*
  Host controller for a serial NAND flash: software writes opcode, address
  and length into local registers, pulses go, and the engine runs one whole
  chip-select frame, streaming data bytes through a one-byte data register.
  Assumes the device sits directly on the o_/i_ pin ports; a bench resolves
  the four shared data lines from the output enables.
*/
`timescale 1ns/1ps
module snf_host (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [31:0] o_rdata,
  output logic o_cs_n,
  output logic o_sck,
  output logic [3:0] o_io_out,
  output logic [3:0] o_io_oe,
  input wire logic [3:0] i_io_in
);
  snf_pkg::snf_state_t state;
  snf_pkg::snf_phase_t phase;
  logic mode3;
  logic err;
  logic [7:0] opcode_r;
  logic [23:0] addr_r;
  logic [11:0] len_r;
  logic [7:0] tx_byte;
  logic tx_full;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [2:0] div_cnt;
  logic tick;
  logic [7:0] sh;
  logic [23:0] a_sh;
  logic [3:0] bit_left;
  logic [11:0] byte_left;
  logic [2:0] lanes;
  logic [1:0] x_na;
  logic [1:0] x_nd;
  logic [11:0] x_ndat;
  logic [2:0] x_alanes;
  logic [2:0] x_dlanes;
  logic x_rd;
  logic [3:0] io_s;
  // decoded shape of the opcode now in the register
  logic [1:0] d_na;
  logic [1:0] d_nd;
  logic [11:0] d_ndat;
  logic [2:0] d_alanes;
  logic [2:0] d_dlanes;
  logic d_rd;
  logic d_col;
  logic d_row;
  logic d_var;
  logic go;
  logic bad;
  logic nxt_any;
  snf_pkg::snf_phase_t nxt_ph;
  logic [11:0] nxt_cnt;
  logic ld_tx;
  logic rx_put;
  logic active;
  logic [7:0] sh_shift;
  logic next_sck;
  logic [3:0] next_out;
  logic [3:0] next_oe;

  function automatic logic [3:0] bits_per(input logic [2:0] l);
    unique case (l)
      snf_pkg::LANE4: bits_per = 4'h2;
      snf_pkg::LANE2: bits_per = 4'h4;
      default: bits_per = 4'h8;
    endcase
  endfunction : bits_per

  function automatic logic [2:0] lanes_of(input snf_pkg::snf_phase_t p, input logic [2:0] al,
                                          input logic [2:0] dl);
    unique case (p)
      snf_pkg::PH_CMD: lanes_of = snf_pkg::LANE1;
      snf_pkg::PH_DATA: lanes_of = dl;
      default: lanes_of = al;
    endcase
  endfunction : lanes_of

  snf_sync #(.WIDTH(4)) u_io_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d(i_io_in),
    .o_q(io_s)
  );

  always_comb begin
    d_na = 2'h0;
    d_nd = 2'h0;
    d_ndat = 12'h000;
    d_alanes = snf_pkg::LANE1;
    d_dlanes = snf_pkg::LANE1;
    d_rd = 1'b0;
    d_col = 1'b0;
    d_row = 1'b0;
    d_var = 1'b0;
    case (opcode_r)
      snf_pkg::OP_GET_FEAT: begin
        d_na = 2'h1;
        d_ndat = snf_pkg::FEAT_BYTES;
        d_rd = 1'b1;
      end
      snf_pkg::OP_SET_FEAT: begin
        d_na = 2'h1;
        d_ndat = snf_pkg::FEAT_BYTES;
      end
      snf_pkg::OP_READ_ID: begin
        d_nd = 2'h1;
        d_ndat = snf_pkg::ID_BYTES;
        d_rd = 1'b1;
      end
      snf_pkg::OP_PAGE_READ, snf_pkg::OP_CACHE_RAND, snf_pkg::OP_ERASE, snf_pkg::OP_PROG_EXEC: begin
        d_na = 2'h3;
        d_row = 1'b1;
      end
      snf_pkg::OP_PERM_LOCK: d_na = 2'h3;
      snf_pkg::OP_RD_X1, snf_pkg::OP_RD_X1_FAST, snf_pkg::OP_RD_X2, snf_pkg::OP_RD_X4,
      snf_pkg::OP_RD_DIO, snf_pkg::OP_RD_QIO: begin
        d_na = 2'h2;
        d_nd = (opcode_r == snf_pkg::OP_RD_QIO) ? 2'h2 : 2'h1;
        d_var = 1'b1;
        d_rd = 1'b1;
        d_col = 1'b1;
        if (opcode_r == snf_pkg::OP_RD_X2 || opcode_r == snf_pkg::OP_RD_DIO) begin
          d_dlanes = snf_pkg::LANE2;
        end
        if (opcode_r == snf_pkg::OP_RD_X4 || opcode_r == snf_pkg::OP_RD_QIO) begin
          d_dlanes = snf_pkg::LANE4;
        end
        if (opcode_r == snf_pkg::OP_RD_DIO || opcode_r == snf_pkg::OP_RD_QIO) begin
          d_alanes = d_dlanes;
        end
      end
      snf_pkg::OP_LOAD_X1, snf_pkg::OP_LOAD_RAND_X1, snf_pkg::OP_LOAD_X4, snf_pkg::OP_LOAD_RAND_X4: begin
        d_na = 2'h2;
        d_var = 1'b1;
        d_col = 1'b1;
        if (opcode_r == snf_pkg::OP_LOAD_X4 || opcode_r == snf_pkg::OP_LOAD_RAND_X4) begin
          d_dlanes = snf_pkg::LANE4;
        end
      end
      // reset, write enable/disable, cache last and unknown codes: opcode only
      default: d_na = 2'h0;
    endcase
    if (d_var) begin
      d_ndat = len_r;
    end
  end

  // refuse any transfer that would touch columns past the page end
  assign bad = d_col && (addr_r[15:12] != 4'h0 || addr_r[11:0] > snf_pkg::COL_LAST ||
               {1'b0, addr_r[11:0]} + {1'b0, len_r} > snf_pkg::PAGE_BYTES || len_r == 12'h000);
  assign go = i_we && i_addr == snf_pkg::REG_CTRL && i_wdata[snf_pkg::CTRL_GO] && state == snf_pkg::ST_IDLE;
  assign active = state != snf_pkg::ST_IDLE && state != snf_pkg::ST_GAP;
  assign tick = div_cnt == snf_pkg::SCK_HALF_LAST;
  assign ld_tx = state == snf_pkg::ST_STALL && !x_rd && tx_full;
  assign rx_put = state == snf_pkg::ST_HIGH && tick && bit_left == 4'h1 && phase == snf_pkg::PH_DATA && x_rd;

  always_comb begin
    nxt_any = 1'b1;
    nxt_ph = snf_pkg::PH_DATA;
    nxt_cnt = x_ndat;
    if (phase == snf_pkg::PH_CMD && x_na != 2'h0) begin
      nxt_ph = snf_pkg::PH_ADDR;
      nxt_cnt = {10'h000, x_na};
    end else if ((phase == snf_pkg::PH_CMD || phase == snf_pkg::PH_ADDR) && x_nd != 2'h0) begin
      nxt_ph = snf_pkg::PH_DUMMY;
      nxt_cnt = {10'h000, x_nd};
    end else if (phase == snf_pkg::PH_DATA || x_ndat == 12'h000) begin
      nxt_any = 1'b0;
    end
  end

  // sample lines from the synchronised copy; msb arrives first
  always_comb begin
    unique case (lanes)
      snf_pkg::LANE4: sh_shift = {sh[3:0], io_s};
      snf_pkg::LANE2: sh_shift = {sh[5:0], io_s[1:0]};
      default: sh_shift = {sh[6:0], io_s[1]};
    endcase
  end

  // divider runs only while a half period is being timed
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt <= 3'h0;
    end else if (state == snf_pkg::ST_IDLE || state == snf_pkg::ST_STALL || tick) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= snf_pkg::ST_IDLE;
      phase <= snf_pkg::PH_CMD;
      sh <= 8'h00;
      a_sh <= 24'h000000;
      bit_left <= 4'h0;
      byte_left <= 12'h000;
      lanes <= snf_pkg::LANE1;
      x_na <= 2'h0;
      x_nd <= 2'h0;
      x_ndat <= 12'h000;
      x_alanes <= snf_pkg::LANE1;
      x_dlanes <= snf_pkg::LANE1;
      x_rd <= 1'b0;
    end else begin
      unique case (state)
        snf_pkg::ST_IDLE: begin
          if (go && !bad) begin
            state <= snf_pkg::ST_SETUP;
            phase <= snf_pkg::PH_CMD;
            sh <= opcode_r;
            bit_left <= 4'h8;
            byte_left <= 12'h001;
            lanes <= snf_pkg::LANE1;
            x_na <= d_na;
            x_nd <= d_nd;
            x_ndat <= d_ndat;
            x_alanes <= d_alanes;
            x_dlanes <= d_dlanes;
            x_rd <= d_rd;
            unique case (d_na)
              2'h1: a_sh <= {addr_r[7:0], 16'h0000};
              2'h2: a_sh <= {addr_r[15:0], 8'h00};
              default: a_sh <= d_row ? {7'h00, addr_r[16:0]} : addr_r;
            endcase
          end
        end
        snf_pkg::ST_SETUP: begin
          if (tick) begin
            state <= snf_pkg::ST_LOW;
          end
        end
        snf_pkg::ST_LOW: begin
          if (tick) begin
            state <= snf_pkg::ST_HIGH;
          end
        end
        snf_pkg::ST_HIGH: begin
          if (tick) begin
            sh <= sh_shift;
            bit_left <= bit_left - 4'h1;
            state <= snf_pkg::ST_LOW;
            if (bit_left == 4'h1) begin
              bit_left <= bits_per(lanes);
              if (byte_left != 12'h001 || nxt_any) begin
                if (byte_left == 12'h001) begin
                  phase <= nxt_ph;
                  byte_left <= nxt_cnt;
                  lanes <= lanes_of(nxt_ph, x_alanes, x_dlanes);
                  bit_left <= bits_per(lanes_of(nxt_ph, x_alanes, x_dlanes));
                end else begin
                  byte_left <= byte_left - 12'h001;
                end
                if ((byte_left == 12'h001 ? nxt_ph : phase) == snf_pkg::PH_DATA) begin
                  state <= snf_pkg::ST_STALL;
                end else if ((byte_left == 12'h001 ? nxt_ph : phase) == snf_pkg::PH_ADDR) begin
                  sh <= a_sh[23:16];
                  a_sh <= {a_sh[15:0], 8'h00};
                end else begin
                  sh <= 8'h00;
                end
              end else begin
                state <= snf_pkg::ST_END;
              end
            end
          end
        end
        snf_pkg::ST_STALL: begin
          // clock held low until software has supplied or taken a byte
          if (x_rd ? !rx_valid : tx_full) begin
            sh <= x_rd ? 8'h00 : tx_byte;
            state <= snf_pkg::ST_LOW;
          end
        end
        snf_pkg::ST_END: begin
          if (tick) begin
            state <= snf_pkg::ST_GAP;
          end
        end
        snf_pkg::ST_GAP: begin
          if (tick) begin
            state <= snf_pkg::ST_IDLE;
          end
        end
        default: state <= snf_pkg::ST_IDLE;
      endcase
    end
  end

  always_comb begin
    next_out = snf_pkg::PIN_IDLE_OUT;
    next_oe = snf_pkg::PIN_IDLE_OE;
    if (active) begin
      if (!(phase == snf_pkg::PH_DATA && x_rd)) begin
        unique case (lanes)
          snf_pkg::LANE4: begin
            next_out = sh[7:4];
            next_oe = 4'hF;
          end
          snf_pkg::LANE2: begin
            next_out[1:0] = sh[7:6];
            next_oe[1] = 1'b1;
          end
          default: next_out[0] = sh[7];
        endcase
      end else begin
        // device drives the data lines; release every lane it uses
        unique case (lanes)
          snf_pkg::LANE4: next_oe = 4'h0;
          snf_pkg::LANE2: next_oe[1:0] = 2'h0;
          default: next_out[0] = 1'b0;
        endcase
      end
    end
  end

  assign next_sck = (state == snf_pkg::ST_HIGH) ? 1'b1 :
                    (state == snf_pkg::ST_LOW || state == snf_pkg::ST_STALL) ? 1'b0 : mode3;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cs_n <= 1'b1;
      o_sck <= 1'b0;
      o_io_out <= snf_pkg::PIN_IDLE_OUT;
      o_io_oe <= snf_pkg::PIN_IDLE_OE;
    end else begin
      o_cs_n <= !active;
      o_sck <= next_sck;
      o_io_out <= next_out;
      o_io_oe <= next_oe;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode3 <= 1'b0;
      opcode_r <= 8'h00;
      addr_r <= 24'h000000;
      len_r <= 12'h000;
      err <= 1'b0;
    end else if (i_we) begin
      unique case (i_addr)
        snf_pkg::REG_CTRL: begin
          if (state == snf_pkg::ST_IDLE) begin
            mode3 <= i_wdata[snf_pkg::CTRL_MODE3];
          end
          if (go) begin
            err <= bad;
          end
        end
        snf_pkg::REG_OPCODE: opcode_r <= i_wdata[7:0];
        snf_pkg::REG_ADDR: addr_r <= i_wdata[23:0];
        snf_pkg::REG_LEN: len_r <= i_wdata[11:0];
        default: err <= err;
      endcase
    end
  end

  // set by software write, cleared when the engine loads the byte
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_full <= 1'b0;
      tx_byte <= 8'h00;
    end else if (i_we && i_addr == snf_pkg::REG_DATA) begin
      tx_full <= 1'b1;
      tx_byte <= i_wdata[7:0];
    end else if (ld_tx) begin
      tx_full <= 1'b0;
    end
  end

  // a byte arriving in the same cycle as the software read wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
    end else if (rx_put) begin
      rx_valid <= 1'b1;
      rx_byte <= sh_shift;
    end else if (i_re && i_addr == snf_pkg::REG_DATA) begin
      rx_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h00000000;
    end else if (i_re) begin
      o_rdata <= 32'h00000000;
      unique case (i_addr)
        snf_pkg::REG_CTRL: begin
          o_rdata[snf_pkg::STAT_BUSY] <= state != snf_pkg::ST_IDLE;
          o_rdata[snf_pkg::STAT_MODE3] <= mode3;
          o_rdata[snf_pkg::STAT_ERR] <= err;
          o_rdata[snf_pkg::STAT_TX_NEED] <= state == snf_pkg::ST_STALL && !x_rd && !tx_full;
          o_rdata[snf_pkg::STAT_RX_VALID] <= rx_valid;
        end
        snf_pkg::REG_OPCODE: o_rdata[7:0] <= opcode_r;
        snf_pkg::REG_ADDR: o_rdata[23:0] <= addr_r;
        snf_pkg::REG_LEN: o_rdata[11:0] <= len_r;
        snf_pkg::REG_DATA: o_rdata[7:0] <= rx_byte;
        default: o_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule : snf_host

// ==== rtl/snf_sync.sv ====
/*
  Two-flop synchroniser for pin inputs.
  Assumes inputs are asynchronous to i_clk; only the second stage is read.
*/
`timescale 1ns/1ps
module snf_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule : snf_sync

// ==== verification/snf_flash_model.sv ====
/*
  Behavioural serial flash: x1, x2 and x4 cache reads, x1 loads, status poll, latch, page read, reset.
  Assumes its input is the resolved bus; busy lasts a number of status polls, not a time.
*/
`timescale 1ns/1ps
module snf_flash_model #(
  parameter int READ_POLLS = 2
) (
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic [3:0] i_io,
  output logic [3:0] o_io_out,
  output logic [3:0] o_io_oe
);
  logic [7:0] cache [0:2175];
  logic [7:0] op = 8'h00;
  logic [15:0] col = 16'h0000;
  logic [7:0] sh = 8'h00;
  logic [7:0] b;
  logic write_enable_latch = 1'b0;
  int nb = 0;
  int busy = 0;
  int k;
  int w;
  initial begin
    o_io_oe = 4'h0;
    o_io_out = 4'h0;
    for (int i = 0; i < 2176; i++) cache[i] = 8'(i * 7);
  end
  // sampling ignores the idle level, so both clock modes work alike
  always @(posedge i_sck) begin
    if (!i_cs_n) begin
      if (nb < 8) op = {op[6:0], i_io[0]};
      else if (nb < 24) col = {col[14:0], i_io[0]};
      else if (op == 8'h02 || op == 8'h84) begin
        sh = {sh[6:0], i_io[0]};
        // bytes past the page end are dropped
        if (nb % 8 == 7) cache[col[11:0]] = sh;
        if (nb % 8 == 7) col = col + 16'h0001;
      end
      nb = nb + 1;
    end
  end
  always @(negedge i_sck) begin
    if (!i_cs_n && op == 8'h0F && nb >= 16 && nb < 24) begin
      o_io_oe = 4'h2;
      b = {6'h00, write_enable_latch, busy != 0};
      o_io_out[1] = b[23 - nb];
    end
    if (!i_cs_n && (op == 8'h03 || op == 8'h0B || op == 8'h3B || op == 8'h6B) && nb >= 32) begin
      w = (op == 8'h6B) ? 4 : (op == 8'h3B) ? 2 : 1;
      k = (nb - 32) * w;
      b = cache[int'(col[11:0]) + k / 8];
      o_io_oe = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h2;
      if (w == 4) o_io_out = (k % 8 != 0) ? b[3:0] : b[7:4];
      else if (w == 2) begin
        // two lines: the higher bit of each pair goes out on line 1
        o_io_out[1] = b[7 - k % 8];
        o_io_out[0] = b[6 - k % 8];
      end
      else o_io_out[1] = b[7 - k % 8];
    end
  end
  // opcodes not listed fall through untouched
  always @(posedge i_cs_n) begin
    o_io_oe = 4'h0;
    if (nb == 8 && op == 8'h06) write_enable_latch = 1'b1;
    if (nb == 8 && (op == 8'h04 || op == 8'hFF)) write_enable_latch = 1'b0;
    if (nb == 8 && op == 8'hFF) busy = 1;
    if (nb == 32 && op == 8'h13) busy = READ_POLLS;
    if (op == 8'h0F && busy > 0) busy = busy - 1;
    nb = 0;
  end
endmodule : snf_flash_model

// ==== verification/snf_host_props.sv ====
/*
  Pin and register port checker for snf_host.
  Assumes it is bound to snf_host and sees only its ports.
*/
`timescale 1ns/1ps
module snf_host_props (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [31:0] o_rdata,
  input wire logic o_cs_n,
  input wire logic o_sck,
  input wire logic [3:0] o_io_out,
  input wire logic [3:0] o_io_oe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_setup_half;
    $stable(o_sck)[*3];
  endsequence
  sequence s_high_half;
    o_sck[*3];
  endsequence
  sequence s_low_half;
    !o_sck[*3];
  endsequence
  // a mode write moves the idle level, so three cycles after it are left out
  a_idle_sck_still: assert property (
    o_cs_n && $past(o_cs_n) && !$past(i_we) && !$past(i_we, 2) && !$past(i_we, 3) |-> $stable(o_sck))
    else $error("sck moved while deselected");
  a_setup_half: assert property (
    $fell(o_cs_n) |=> s_setup_half) else $error("sck moved in setup half");
  a_high_half: assert property (
    $rose(o_sck) && !o_cs_n |=> s_high_half) else $error("short high half");
  a_low_half: assert property (
    $fell(o_sck) && !o_cs_n |=> s_low_half) else $error("short low half");
  a_lines_hold: assert property (
    $rose(o_sck) && !o_cs_n |=> ($stable(o_io_out) && $stable(o_io_oe))[*3])
    else $error("lines changed while sck high");
  a_cs_gap: assert property (
    $rose(o_cs_n) |=> o_cs_n[*3]) else $error("deselect gap too short");
  a_idle_lines: assert property (
    o_cs_n && $past(o_cs_n) && $past(o_cs_n, 2) |-> o_io_oe == snf_pkg::PIN_IDLE_OE
      && o_io_out == snf_pkg::PIN_IDLE_OUT) else $error("idle lines wrong");
  a_rdata_hold: assert property (
    !$past(i_re) |-> $stable(o_rdata)) else $error("read data moved without read");
endmodule : snf_host_props

bind snf_host snf_host_props snf_host_props_u (.i_clk(i_clk), .i_rst(i_rst), .i_we(i_we), .i_re(i_re),
  .o_rdata(o_rdata), .o_cs_n(o_cs_n), .o_sck(o_sck), .o_io_out(o_io_out), .o_io_oe(o_io_oe));

// ==== verification/tb.sv ====
/*
  Self-checking bench for snf_host against the flash model.
  Assumes the register map and status bits of snf_pkg.
*/
`timescale 1ns/1ps
module tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_we = 1'b0;
  logic i_re = 1'b0;
  logic [31:0] rdata;
  logic cs_n, sck, flip = 1'b0, m = 1'b0, twel = 1'b0;
  logic [3:0] io_out, io_oe, dev_out, dev_oe, io_in;
  logic [7:0] tcache [0:2175];
  logic [7:0] rxq [$];
  logic [7:0] txq [$];
  logic [7:0] rd_ops [4] = '{8'h03, 8'h0B, 8'h6B, 8'h3B};
  int err_count = 0, tests_run = 0, frames = 0, tbusy = 0;
  int unsigned seed;
  always #5 i_clk = ~i_clk;
  // undriven lines toggle so a stale value cannot pass
  always @(posedge i_clk) flip <= ~flip;
  always @(negedge cs_n) frames++;
  assign io_in = (io_oe & io_out) | (~io_oe & dev_oe & dev_out) | (~io_oe & ~dev_oe & {4{flip}});
  snf_host dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
    .i_re(i_re), .o_rdata(rdata), .o_cs_n(cs_n), .o_sck(sck), .o_io_out(io_out), .o_io_oe(io_oe),
    .i_io_in(io_in));
  snf_flash_model dev_u (.i_cs_n(cs_n), .i_sck(sck), .i_io(io_in), .o_io_out(dev_out), .o_io_oe(dev_oe));
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) err_count++;
    if (g !== e) $display("unexpected %s expected %0h seen %0h", nm, e, g);
  endtask : chk_reg
  task automatic chk_data(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) err_count++;
    if (g !== e) $display("unexpected %s expected %0h seen %0h", nm, e, g);
  endtask : chk_data
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_we <= 1'b1;
    @(posedge i_clk);
    i_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_re <= 1'b1;
    @(posedge i_clk);
    i_re <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic xfer(input logic [7:0] op, input logic [23:0] ad, input logic [11:0] n);
    logic [31:0] s;
    int i;
    wr(snf_pkg::REG_OPCODE, {24'h0, op});
    wr(snf_pkg::REG_ADDR, {8'h0, ad});
    wr(snf_pkg::REG_LEN, {20'h0, n});
    wr(snf_pkg::REG_CTRL, {30'h0, m, 1'b1});
    for (i = 0; i < 5000; i++) begin
      rd(snf_pkg::REG_CTRL, s);
      if (s[snf_pkg::STAT_RX_VALID] === 1'b1 && rxq.size() > 0) begin
        rd(snf_pkg::REG_DATA, s);
        chk_data("rx byte", rxq.pop_front(), s[7:0]);
      end else if (s[snf_pkg::STAT_TX_NEED] === 1'b1 && txq.size() > 0) wr(snf_pkg::REG_DATA, {24'h0, txq.pop_front()});
      else if (s[snf_pkg::STAT_BUSY] === 1'b0) break;
    end
    chk_reg("bytes left", 0, rxq.size() + txq.size() + (i == 5000));
  endtask : xfer
  task automatic status_poll;
    rxq.push_back({6'h00, twel, tbusy != 0});
    if (tbusy > 0) tbusy--;
    xfer(8'h0F, 24'h0000C0, 12'h001);
  endtask : status_poll
  initial begin
    #600000;
    err_count++;
    report_and_stop;
  end
  initial begin
    logic [31:0] s;
    int col, n, f;
    logic [7:0] b;
    for (int i = 0; i < 2176; i++) tcache[i] = 8'(i * 7);
    seed = $urandom(37354);
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(snf_pkg::REG_CTRL, s);
    chk_reg("ctrl after reset", 32'h0, s);
    wr(4'hF, 32'hFFFFFFFF);
    rd(4'hF, s);
    chk_reg("unmapped read", 32'h0, s);
    $display("test reset done");
    for (int j = 0; j < 4; j++) begin
      m = j[0];
      wr(snf_pkg::REG_CTRL, {30'h0, m, 1'b0});
      repeat (4) @(posedge i_clk);
      chk_reg("idle sck", {31'h0, m}, {31'h0, sck});
      xfer(8'h06, 24'h0, 12'h0);
      twel = 1'b1;
      status_poll();
      xfer(8'h55, 24'h0, 12'h0);
      status_poll();
      xfer(8'h04, 24'h0, 12'h0);
      twel = 1'b0;
      status_poll();
      col = $urandom % 2170;
      n = 1 + $urandom % 4;
      for (int i = 0; i < n; i++) begin
        b = 8'($urandom);
        txq.push_back(b);
        tcache[col + i] = b;
      end
      xfer(8'h02, 24'(col), 12'(n));
      b = 8'($urandom);
      txq.push_back(b);
      tcache[col + 1] = b;
      xfer(8'h84, 24'(col + 1), 12'h001);
      for (int i = 0; i <= n; i++) rxq.push_back(tcache[col + i]);
      xfer(rd_ops[j], 24'(col), 12'(n + 1));
      $display("test mode %0d op %0h done", m, rd_ops[j]);
    end
    f = frames;
    xfer(8'h03, 24'h00087F, 12'h002);
    rd(snf_pkg::REG_CTRL, s);
    chk_reg("page end refused", {31'h0, 1'b1}, {31'h0, s[snf_pkg::STAT_ERR]});
    chk_reg("no frame sent", f, frames);
    rxq.push_back(tcache[2175]);
    xfer(8'h03, 24'h00087F, 12'h001);
    $display("test bounds done");
    xfer(8'h13, 24'($urandom & 32'h1FFFF), 12'h0);
    tbusy = 2;
    repeat (3) status_poll();
    rxq.push_back(tcache[0]);
    xfer(8'h03, 24'h0, 12'h001);
    xfer(8'h06, 24'h0, 12'h0);
    xfer(8'hFF, 24'h0, 12'h0);
    tbusy = 1;
    repeat (2) status_poll();
    $display("test page read and reset done");
    report_and_stop;
  end
endmodule : tb
